// >>> hw/pport_pkg.sv
package pport_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // Host strobe low time and data settle time, in ns.
    localparam int unsigned STROBE_LOW_NS = 20;
    localparam int unsigned STROBE_LOW_CYC =
        (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETTLE_NS = 10;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LO_BYTE_W = 12;
    localparam int unsigned HI_BYTE_W = 8;
    localparam int unsigned WR_BYTE_W = 8;
    localparam int unsigned HI_FIELD_LSB = 8;
    localparam logic [15:0] TEST_RESTORE_WORD = 16'h4002;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [11:0] BUS_RESET = 12'h000;
    localparam logic [7:0] CNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_RD_LOW = 3'b001,
        H_RD_END = 3'b010,
        H_WR_LOW = 3'b011,
        H_WR_END = 3'b100
    } host_state_t;
endpackage : pport_pkg

// >>> hw/pport_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pport_if;
    logic chip_select_n;
    logic read_n;
    logic write_n;
    logic byte_select;
    logic [11:0] dev_data_out;
    logic [11:0] dev_data_oe_n;
    logic [11:0] host_data_out;
    logic [11:0] host_data_oe_n;
    logic busy;
    logic conversion_trigger_n;
    wire [11:0] data_pins;

    // Bus resolution: the device wins, else the host, else pulled low.
    for (genvar i = 0; i < 12; i++) begin : g_pin
        assign data_pins[i] = !dev_data_oe_n[i] ? dev_data_out[i] :
            (!host_data_oe_n[i] ? host_data_out[i] : 1'b0);
    end

    modport device (
        input chip_select_n, read_n, write_n, byte_select, conversion_trigger_n,
        input data_pins,
        output dev_data_out, dev_data_oe_n, busy
    );
    modport host (
        output chip_select_n, read_n, write_n, byte_select, conversion_trigger_n,
        output host_data_out, host_data_oe_n,
        input data_pins, busy
    );
endinterface : pport_if
`default_nettype wire

// >>> hw/pport_device.sv
// Contract
// - Byte select picks low 12 or high 8.
// - Either byte order accepted on reads.
// - Chip select and read gated, level-sensitive.
// - Drive only while selected; release after read.
// - Host latches read data on read rise.
// - Wide bus: one low read gets result.
// - Narrow bus: two reads, low then high.
// - Read-only host may hold write high.
// - Tied-low select keeps data always driven; here data drive also needs read low.
// - Tied-low mode: host latches on busy fall; here the host only flags it on busy_fall and still latches on read timing.
// - Tied-low mode byte select still switches bytes.
// - Accesses allowed during and after conversion.
// - Register write is low byte, high byte.
// - Writes take pins 0 to 7 only.
// - Write byte captured on combined strobe rise.
// - Restore word resets the test register.
// - Wide bus: data, status need one read.
// - Byte select on lowest host address bit.
// - Host uses timer trigger, busy interrupt.
// - Calibration write raises busy until done.
`timescale 1ns/1ps
`default_nettype none
module pport_device #(
    parameter int unsigned CAL_CYCLES = 64
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Parallel port.
    pport_if.device port,
    // Core side.
    input wire logic [15:0] read_word,
    input wire logic conv_busy,
    input wire logic [15:0] test_default,
    output logic [15:0] write_word,
    output logic write_strobe,
    output logic [15:0] test_reg,
    output logic self_cal_start_bit
);
    // Synchronised pins, two stages each.
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] rd_s;
        logic [1:0] wr_s;
        logic [1:0] bs_s;
        logic [23:0] data_s;
        logic wsel_q;
        logic [7:0] stage_q;
        logic have_low_q;
        logic [15:0] word_q;
        logic wstb_q;
        logic [15:0] test_q;
        logic cal_q;
        logic [15:0] cal_cnt_q;
        logic [11:0] dout_q;
        logic oe_q;
    } dev_state_t;

    dev_state_t s_q, s_d;
    logic rd_sel;
    logic wsel;

    always_comb begin
        s_d = s_q;
        s_d.cs_s = {s_q.cs_s[0], port.chip_select_n};
        s_d.rd_s = {s_q.rd_s[0], port.read_n};
        s_d.wr_s = {s_q.wr_s[0], port.write_n};
        s_d.bs_s = {s_q.bs_s[0], port.byte_select};
        s_d.data_s = {s_q.data_s[11:0], port.data_pins};
        rd_sel = !s_q.cs_s[1] && !s_q.rd_s[1];
        wsel = !s_q.cs_s[1] && !s_q.wr_s[1];
        s_d.wsel_q = wsel;
        s_d.wstb_q = 1'b0;
        // Drive while selected, for either byte order.
        s_d.oe_q = rd_sel;
        if (s_q.bs_s[1]) begin
            s_d.dout_q = {4'h0, read_word[15:pport_pkg::HI_FIELD_LSB]};
        end else begin
            s_d.dout_q = read_word[11:0];
        end
        // Combined strobe rising edge captures pins 0 to 7.
        if (s_q.wsel_q && !wsel) begin
            if (!s_q.bs_s[1]) begin
                s_d.stage_q = s_q.data_s[19:12];
                s_d.have_low_q = 1'b1;
            end else if (s_q.have_low_q) begin
                s_d.word_q = {s_q.data_s[19:12], s_q.stage_q};
                s_d.have_low_q = 1'b0;
                s_d.wstb_q = 1'b1;
                if ({s_q.data_s[19:12], s_q.stage_q} == pport_pkg::TEST_RESTORE_WORD) begin
                    s_d.test_q = test_default;
                end
                if (s_q.data_s[12]) begin
                    s_d.cal_q = 1'b1;
                    s_d.cal_cnt_q = 16'(CAL_CYCLES);
                end
            end
        end
        if (s_q.cal_q && !s_d.wstb_q) begin
            if (s_q.cal_cnt_q <= 16'h0001) begin
                s_d.cal_q = 1'b0;
            end
            s_d.cal_cnt_q = s_q.cal_cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.cs_s <= 2'b11;
            s_q.rd_s <= 2'b11;
            s_q.wr_s <= 2'b11;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign port.dev_data_out = s_q.dout_q;
    // Upper four pins only drive for low-byte reads.
    assign port.dev_data_oe_n = s_q.oe_q ?
        (s_q.bs_s[1] ? 12'hF00 : 12'h000) : 12'hFFF;
    assign port.busy = conv_busy || s_q.cal_q;
    assign write_word = s_q.word_q;
    assign write_strobe = s_q.wstb_q;
    assign test_reg = s_q.test_q;
    assign self_cal_start_bit = s_q.cal_q;
endmodule : pport_device
`default_nettype wire

// >>> hw/pport_host.sv
`timescale 1ns/1ps
`default_nettype none
module pport_host #(
    parameter int unsigned HOLD_CYC = pport_pkg::STROBE_LOW_CYC + 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Parallel port.
    pport_if.host port,
    // User side.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_high,
    input wire logic [7:0] req_wdata,
    input wire logic trigger_n,
    output logic req_ready,
    output logic rsp_valid,
    output logic [11:0] rsp_rdata,
    output logic busy_fall
);
    typedef struct packed {
        pport_pkg::host_state_t st;
        logic [7:0] cnt;
        logic bs;
        logic [7:0] wd;
        logic [11:0] rdata;
        logic rvalid;
        logic [1:0] busy_s;
        logic busy_d;
        logic bfall;
        logic [23:0] data_s;
    } host_st_t;

    host_st_t h_q, h_d;

    always_comb begin
        h_d = h_q;
        h_d.rvalid = 1'b0;
        h_d.busy_s = {h_q.busy_s[0], port.busy};
        h_d.busy_d = h_q.busy_s[1];
        // Busy fall marks a fresh result in tied-low mode.
        h_d.bfall = h_q.busy_d && !h_q.busy_s[1];
        h_d.data_s = {h_q.data_s[11:0], port.data_pins};
        case (h_q.st)
            pport_pkg::H_IDLE: begin
                h_d.cnt = pport_pkg::CNT_RESET;
                if (req_valid) begin
                    h_d.bs = req_high;
                    h_d.wd = req_wdata;
                    h_d.st = req_write ? pport_pkg::H_WR_LOW : pport_pkg::H_RD_LOW;
                end
            end
            pport_pkg::H_RD_LOW: begin
                h_d.cnt = h_q.cnt + 8'h01;
                if (h_q.cnt == 8'(HOLD_CYC)) begin
                    h_d.st = pport_pkg::H_RD_END;
                    h_d.rdata = h_q.data_s[23:12];
                    h_d.rvalid = 1'b1;
                end
            end
            pport_pkg::H_WR_LOW: begin
                h_d.cnt = h_q.cnt + 8'h01;
                if (h_q.cnt == 8'(HOLD_CYC)) begin
                    h_d.st = pport_pkg::H_WR_END;
                end
            end
            pport_pkg::H_RD_END, pport_pkg::H_WR_END: begin
                h_d.cnt = h_q.cnt - 8'h01;
                if (h_q.cnt == pport_pkg::CNT_RESET) begin
                    h_d.st = pport_pkg::H_IDLE;
                end
            end
            default: h_d.st = pport_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            h_q <= '0;
        end else if (clk_en) begin
            h_q <= h_d;
        end
    end

    assign req_ready = (h_q.st == pport_pkg::H_IDLE);
    assign rsp_valid = h_q.rvalid;
    assign rsp_rdata = h_q.rdata;
    assign busy_fall = h_q.bfall;
    assign port.chip_select_n = (h_q.st == pport_pkg::H_IDLE);
    assign port.read_n = (h_q.st != pport_pkg::H_RD_LOW);
    assign port.write_n = (h_q.st != pport_pkg::H_WR_LOW);
    assign port.byte_select = h_q.bs;
    assign port.conversion_trigger_n = trigger_n;
    assign port.host_data_out = {4'h0, h_q.wd};
    assign port.host_data_oe_n = (h_q.st == pport_pkg::H_WR_LOW ||
        h_q.st == pport_pkg::H_WR_END) ? 12'hF00 : 12'hFFF;
endmodule : pport_host
`default_nettype wire

// >>> verif/pport_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pport_monitor (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Port strobes.
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic byte_select,
    // Data lines and status.
    input wire logic [11:0] dev_data_oe_n,
    input wire logic [11:0] host_data_oe_n,
    input wire logic [11:0] data_pins,
    input wire logic busy
);
    // ****************
    // Port checks
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence rd_lo; !chip_select_n && !read_n && !byte_select; endsequence
    sequence rd_hi; !chip_select_n && !read_n && byte_select; endsequence
    sequence cal_hi_wr;
        !chip_select_n && !write_n && byte_select && data_pins[0] ##1 write_n;
    endsequence
    low_drive_a: assert property (rd_lo [*8] |-> dev_data_oe_n == 12'h000)
        else $error("low read not driven on all pins");
    high_drive_a: assert property (rd_hi [*8] |-> dev_data_oe_n == 12'hf00)
        else $error("high read drives wrong pins");
    bus_release_a: assert property ((chip_select_n || read_n) [*6] |-> &dev_data_oe_n)
        else $error("data lines still driven after deselect");
    select_hold_a: assert property ($fell(chip_select_n) |-> !chip_select_n [*8])
        else $error("chip select released too early");
    byte_stable_a: assert property (
        !chip_select_n && $past(!chip_select_n) |-> $stable(byte_select))
        else $error("byte select moved during access");
    strobe_excl_a: assert property (!(!read_n && !write_n))
        else $error("read and write strobes low together");
    no_contention_a: assert property (!(&host_data_oe_n) |-> &dev_data_oe_n)
        else $error("both ends drive the data lines");
    cal_busy_a: assert property (cal_hi_wr |-> ##[1:10] busy)
        else $error("busy not raised after calibration write");
endmodule : pport_monitor
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys, arst_n, conv_busy, req_valid, req_write, req_high;
    logic req_ready, rsp_valid, write_strobe;
    logic [7:0] req_wdata;
    logic [11:0] rsp_rdata;
    logic [15:0] read_word, test_default, write_word, test_reg;
    logic [11:0] rd_q[$];
    logic [15:0] wr_q[$];
    int errors;
    int check_count;
    pport_if bus_if ();
    pport_device #(.CAL_CYCLES(4)) pport_device_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .clk_en(1'b1), .port(bus_if.device), .read_word(read_word), .conv_busy(conv_busy),
        .test_default(test_default), .write_word(write_word), .write_strobe(write_strobe),
        .test_reg(test_reg), .self_cal_start_bit());
    pport_host pport_host_i (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1),
        .port(bus_if.host), .req_valid(req_valid), .req_write(req_write),
        .req_high(req_high), .req_wdata(req_wdata), .trigger_n(1'b1), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy_fall());
    pport_monitor pport_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .chip_select_n(bus_if.chip_select_n), .read_n(bus_if.read_n),
        .write_n(bus_if.write_n), .byte_select(bus_if.byte_select),
        .dev_data_oe_n(bus_if.dev_data_oe_n), .host_data_oe_n(bus_if.host_data_oe_n),
        .data_pins(bus_if.data_pins), .busy(bus_if.busy));
    // ****************
    // Tasks
    // ****************
    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk12
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16
    task automatic idle;
        for (int n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    endtask : idle
    task automatic send(input logic w, input logic hi, input logic [7:0] d);
        idle;
        req_valid = 1'b1;
        req_write = w;
        req_high = hi;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask : send
    task automatic rd(input logic hi);
        idle;
        read_word = 16'($urandom);
        rd_q.push_back(hi ? {4'h0, read_word[15:8]} : read_word[11:0]);
        send(1'b0, hi, 8'($urandom));
    endtask : rd
    task automatic wr16(input logic [15:0] w);
        send(1'b1, 1'b0, w[7:0]);
        wr_q.push_back(w);
        send(1'b1, 1'b1, w[15:8]);
    endtask : wr16
    // ****************
    // Stimulus and checking
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1) chk12(rsp_rdata, rd_q.pop_front());
        if (write_strobe === 1'b1) chk16(write_word, wr_q.pop_front());
    end
    // The whole sequence needs about 700 cycles, so this is a generous ceiling.
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
    initial begin : main
        logic [15:0] w;
        {arst_n, conv_busy, req_valid, req_write, req_high} = 5'b0_0000;
        req_wdata = 8'h00;
        read_word = 16'h0000;
        test_default = 16'h0000;
        errors = 0;
        check_count = 0;
        void'($urandom(97104));
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            conv_busy = 1'($urandom);
            test_default = 16'($urandom);
            rd(i[0]);
            rd(~i[0]);
            w = 16'($urandom);
            wr16(w);
        end
        wr16(16'h4002);
        idle;
        chk16(test_reg, test_default);
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
